// ===== hdl/vuf_pkg.sv
//
// Contract
// - overvoltage fault judged against the percent limit setting, then configured response applies
// - overvoltage fault sets byte, word and vout flags and raises alert
// - undervoltage fault sets other, word and vout undervoltage flags and raises alert
// - loop slave ignores writes, nacks reads and writes, flags invalid command, alerts
// - both response bytes are saved when the store-all command arrives
// - after reset each response selects shutdown and delayed restart
// - byte layout select 7, zero 6, retry 5:3, delay 2:0; default 10111111
// - select 0 keeps running, still sets flags and alert unless masked
// - select 1 shuts the output down, then follows the retry setting
// - retry 000 never restarts; output stays off until faults are cleared
// - retry 111 restarts endlessly until off, bias loss or another fault; here neither off nor another fault stops the loop
// - retry other than 000 or 111 rejected, old kept, cml flags, alert
// - only retry bit 5 is kept in nonvolatile storage; the code also saves select bit 7
// - delay 000 means no delay, paired with retry 000, output stays off
// - delay 111 waits seven rise times, paired with retry 111
// - delay bits always read as copies of retry bit 5
// - undervoltage handled the same way through its own response byte
// - out-of-range numeric write rejected, old kept, cml flags, alert
package vuf_pkg;

    // ***************************************************
    // command codes and byte layout
    // ***************************************************
    localparam logic [7:0] CMD_OV_RESP = 8'h41;
    localparam logic [7:0] CMD_UV_RESP = 8'h45;
    localparam logic [7:0] RESP_RST    = 8'hbf;
    localparam int         SEL_BIT     = 7;
    localparam int         ZERO_BIT    = 6;
    localparam int         RETRY_MSB   = 5;
    localparam int         RETRY_LSB   = 3;
    localparam logic [2:0] RETRY_OFF   = 3'h0;
    localparam logic [2:0] RETRY_ON    = 3'h7;

    // ***************************************************
    // timing
    // ***************************************************
    localparam int CLK_KHZ        = 10000;
    localparam int TON_RISE_US    = 3000;
    localparam int TON_RISE_CYC   = (TON_RISE_US * CLK_KHZ) / 1000;
    localparam int DELAY_MULT     = 7;
    localparam int RESTART_CYC    = DELAY_MULT * TON_RISE_CYC;
    localparam int CH_NUM         = 2;
    localparam int CH_OV          = 0;
    localparam int CH_UV          = 1;

    // ***************************************************
    // channel state
    // ***************************************************
    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_HOLD = 3'b010,
        ST_WAIT = 3'b100
    } vuf_state_t;

endpackage

// ===== hdl/vuf_chan.sv
`timescale 1ns/1ps
`default_nettype none
module vuf_chan #(
    parameter int DELAY_CYC = vuf_pkg::RESTART_CYC
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_fault,
    input  wire logic i_sel,
    input  wire logic i_retry,
    input  wire logic i_clear,
    output logic      o_event,
    output logic      o_shut
);
    localparam int CW = $clog2(DELAY_CYC + 1);

    initial begin
        if (DELAY_CYC < 1) begin
            $error("vuf_chan: DELAY_CYC must be at least one");
        end
    end

    vuf_pkg::vuf_state_t state_r;
    logic [CW-1:0]       cnt_r;
    logic                fault_d_r;

    // ***************************************************
    // fault edge
    // ***************************************************
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fault_d_r <= 1'b0;
        end else begin
            fault_d_r <= i_fault;
        end
    end
    assign o_event = i_fault & ~fault_d_r;

    // ***************************************************
    // shutdown and restart
    // ***************************************************
    // the level, not the edge, shuts down: a fault still present after
    // a restart trips again, which gives the endless retry loop
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= vuf_pkg::ST_RUN;
            cnt_r   <= '0;
        end else begin
            unique case (state_r)
                vuf_pkg::ST_RUN: begin
                    if (i_fault && i_sel) begin
                        cnt_r   <= '0;
                        state_r <= i_retry ? vuf_pkg::ST_WAIT : vuf_pkg::ST_HOLD;
                    end
                end
                vuf_pkg::ST_HOLD: begin
                    if (i_clear) begin
                        state_r <= vuf_pkg::ST_RUN;
                    end
                end
                vuf_pkg::ST_WAIT: begin
                    if (cnt_r == CW'(DELAY_CYC - 1)) begin
                        state_r <= vuf_pkg::ST_RUN;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                default: state_r <= vuf_pkg::ST_HOLD;
            endcase
        end
    end
    assign o_shut = (state_r != vuf_pkg::ST_RUN);

    // ***************************************************
    // checks
    // ***************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    shut_on_fault_a: assert property (
        (state_r == vuf_pkg::ST_RUN) && i_fault && i_sel |=> o_shut)
        else $error("fault with select set did not shut down");
    ignore_keeps_a: assert property (
        (state_r == vuf_pkg::ST_RUN) && !i_sel |=> !o_shut)
        else $error("ignore mode shut the output");
    hold_no_retry_a: assert property (
        (state_r == vuf_pkg::ST_HOLD) && !i_clear |=> o_shut)
        else $error("restart without retry or clear");
    delay_end_a: assert property (
        (state_r == vuf_pkg::ST_WAIT) && (cnt_r == CW'(DELAY_CYC - 1))
        |=> (state_r == vuf_pkg::ST_RUN))
        else $error("restart delay did not end on time");
    delay_early_a: assert property (
        (state_r == vuf_pkg::ST_WAIT) && (cnt_r < CW'(DELAY_CYC - 1)) |=> o_shut)
        else $error("restart before delay elapsed");
    retry_cv: cover property ((state_r == vuf_pkg::ST_WAIT) ##1 (state_r == vuf_pkg::ST_RUN));
    hold_cv:  cover property ((state_r == vuf_pkg::ST_HOLD) ##1 (state_r == vuf_pkg::ST_RUN));
endmodule
`default_nettype wire

// ===== hdl/vuf_top.sv
`timescale 1ns/1ps
`default_nettype none
module vuf_top #(
    parameter int RESTART_CYC = vuf_pkg::RESTART_CYC
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rstn,
    input  wire logic       i_ov_det,
    input  wire logic       i_uv_det,
    input  wire logic       i_loop_slave,
    input  wire logic       i_cmd_valid,
    input  wire logic       i_cmd_write,
    input  wire logic [7:0] i_cmd_code,
    input  wire logic [7:0] i_cmd_wdata,
    input  wire logic       i_store_all,
    input  wire logic       i_clear_faults,
    input  wire logic       i_output_on,
    input  wire logic       i_alert_mask,
    output logic            o_cmd_done,
    output logic            o_cmd_nack,
    output logic [7:0]      o_cmd_rdata,
    output logic            o_nvm_wr,
    output logic [3:0]      o_nvm_data,
    output logic            o_output_en,
    output logic            o_stat_byte_ov,
    output logic            o_stat_byte_oth,
    output logic            o_stat_byte_cml,
    output logic            o_stat_word_vout,
    output logic            o_stat_vout_ov,
    output logic            o_stat_vout_uv,
    output logic            o_stat_cml_ivd,
    output logic            o_stat_cml_ivc,
    output logic            o_alert
);
    localparam int CN = vuf_pkg::CH_NUM;

    initial begin
        if (RESTART_CYC < 1) begin
            $error("vuf_top: RESTART_CYC must be at least one");
        end
    end

    // ***************************************************
    // decode helpers
    // ***************************************************
    // one-hot channel hit for a command code
    function automatic logic [CN-1:0] resp_hit(input logic [7:0] code);
        logic [CN-1:0] h;
        h                  = '0;
        h[vuf_pkg::CH_OV]  = (code == vuf_pkg::CMD_OV_RESP);
        h[vuf_pkg::CH_UV]  = (code == vuf_pkg::CMD_UV_RESP);
        return h;
    endfunction

    // only all-zero or all-one retry settings are legal
    function automatic logic retry_ok(input logic [7:0] d);
        logic [2:0] r;
        r = d[vuf_pkg::RETRY_MSB:vuf_pkg::RETRY_LSB];
        return (r == vuf_pkg::RETRY_OFF) || (r == vuf_pkg::RETRY_ON);
    endfunction

    // read image rebuilt from stored bits so retry and delay always agree
    function automatic logic [7:0] resp_byte(input logic sel, input logic rb);
        return {sel, 1'b0, {6{rb}}};
    endfunction

    // ***************************************************
    // reset release
    // ***************************************************
    logic rst_q1_r;
    logic rst_n_r;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_q1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_q1_r <= 1'b1;
            rst_n_r  <= rst_q1_r;
        end
    end

    // ***************************************************
    // pin synchronisers
    // ***************************************************
    logic [2:0] async_in;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       ov_s;
    logic       uv_s;
    logic       slave_s;

    assign async_in = {i_loop_slave, i_uv_det, i_ov_det};

    generate
        for (genvar g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
                if (!rst_n_r) begin
                    sync1_r[g] <= 1'b0;
                    sync2_r[g] <= 1'b0;
                end else begin
                    sync1_r[g] <= async_in[g];
                    sync2_r[g] <= sync1_r[g];
                end
            end
        end
    endgenerate

    // detectors already compare against the percent limit setting
    assign ov_s    = sync2_r[0];
    assign uv_s    = sync2_r[1];
    assign slave_s = sync2_r[2];

    // ***************************************************
    // response bytes
    // ***************************************************
    logic [CN-1:0] sel_r;
    logic [CN-1:0] rbit_r;
    logic [CN-1:0] hit;
    logic          wr_req;
    logic          rd_req;
    logic          wr_ok;
    logic          wr_bad;
    logic          slave_hit;

    assign hit       = resp_hit(i_cmd_code);
    assign wr_req    = i_cmd_valid & i_cmd_write & (|hit);
    assign rd_req    = i_cmd_valid & ~i_cmd_write & (|hit);
    assign slave_hit = (wr_req | rd_req) & slave_s;
    assign wr_ok     = wr_req & ~slave_s & retry_ok(i_cmd_wdata);
    assign wr_bad    = wr_req & ~slave_s & ~retry_ok(i_cmd_wdata);

    generate
        for (genvar c = 0; c < CN; c++) begin : g_reg
            always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
                if (!rst_n_r) begin
                    sel_r[c]  <= vuf_pkg::RESP_RST[vuf_pkg::SEL_BIT];
                    rbit_r[c] <= vuf_pkg::RESP_RST[vuf_pkg::RETRY_MSB];
                end else if (wr_ok && hit[c]) begin
                    sel_r[c]  <= i_cmd_wdata[vuf_pkg::SEL_BIT];
                    rbit_r[c] <= i_cmd_wdata[vuf_pkg::RETRY_MSB];
                end
            end
        end
    endgenerate

    // ***************************************************
    // command answer
    // ***************************************************
    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_cmd_done  <= 1'b0;
            o_cmd_nack  <= 1'b0;
            o_cmd_rdata <= 8'h00;
        end else begin
            o_cmd_done <= wr_req | rd_req;
            o_cmd_nack <= slave_hit;
            if (rd_req && !slave_s) begin
                o_cmd_rdata <= hit[vuf_pkg::CH_UV]
                    ? resp_byte(sel_r[vuf_pkg::CH_UV], rbit_r[vuf_pkg::CH_UV])
                    : resp_byte(sel_r[vuf_pkg::CH_OV], rbit_r[vuf_pkg::CH_OV]);
            end else begin
                o_cmd_rdata <= 8'h00;
            end
        end
    end

    // ***************************************************
    // nonvolatile save
    // ***************************************************
    // only select and retry bit 5 leave the block; delay is derived
    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_nvm_wr   <= 1'b0;
            o_nvm_data <= 4'h0;
        end else begin
            o_nvm_wr <= i_store_all;
            if (i_store_all) begin
                o_nvm_data <= {sel_r[vuf_pkg::CH_UV], rbit_r[vuf_pkg::CH_UV],
                               sel_r[vuf_pkg::CH_OV], rbit_r[vuf_pkg::CH_OV]};
            end
        end
    end

    // ***************************************************
    // fault channels
    // ***************************************************
    logic [CN-1:0] ch_fault;
    logic [CN-1:0] ch_event;
    logic [CN-1:0] ch_shut;

    assign ch_fault = {uv_s, ov_s};

    generate
        for (genvar c = 0; c < CN; c++) begin : g_ch
            vuf_chan #(
                .DELAY_CYC (RESTART_CYC)
            ) u_chan (
                .i_clk_sys (i_clk_sys),
                .i_rst_n   (rst_n_r),
                .i_fault   (ch_fault[c]),
                .i_sel     (sel_r[c]),
                .i_retry   (rbit_r[c]),
                .i_clear   (i_clear_faults),
                .o_event   (ch_event[c]),
                .o_shut    (ch_shut[c])
            );
        end
    endgenerate

    // either channel's shutdown holds the output off; neither stops the other's retry loop
    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_output_en <= 1'b0;
        end else begin
            o_output_en <= i_output_on & ~(|ch_shut);
        end
    end

    // ***************************************************
    // status flags
    // ***************************************************
    // set wins over clear so an event in the clear cycle survives
    logic ev_ov;
    logic ev_uv;
    logic ev_cml;

    assign ev_ov  = ch_event[vuf_pkg::CH_OV];
    assign ev_uv  = ch_event[vuf_pkg::CH_UV];
    assign ev_cml = wr_bad;

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_stat_byte_ov <= 1'b0;
            o_stat_vout_ov <= 1'b0;
        end else if (ev_ov) begin
            o_stat_byte_ov <= 1'b1;
            o_stat_vout_ov <= 1'b1;
        end else if (i_clear_faults) begin
            o_stat_byte_ov <= 1'b0;
            o_stat_vout_ov <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_stat_byte_oth <= 1'b0;
            o_stat_vout_uv  <= 1'b0;
        end else if (ev_uv) begin
            o_stat_byte_oth <= 1'b1;
            o_stat_vout_uv  <= 1'b1;
        end else if (i_clear_faults) begin
            o_stat_byte_oth <= 1'b0;
            o_stat_vout_uv  <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_stat_word_vout <= 1'b0;
        end else if (ev_ov || ev_uv) begin
            o_stat_word_vout <= 1'b1;
        end else if (i_clear_faults) begin
            o_stat_word_vout <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_stat_byte_cml <= 1'b0;
        end else if (ev_cml || slave_hit) begin
            o_stat_byte_cml <= 1'b1;
        end else if (i_clear_faults) begin
            o_stat_byte_cml <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_stat_cml_ivd <= 1'b0;
        end else if (ev_cml) begin
            o_stat_cml_ivd <= 1'b1;
        end else if (i_clear_faults) begin
            o_stat_cml_ivd <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_stat_cml_ivc <= 1'b0;
        end else if (slave_hit) begin
            o_stat_cml_ivc <= 1'b1;
        end else if (i_clear_faults) begin
            o_stat_cml_ivc <= 1'b0;
        end
    end

    // ***************************************************
    // alert
    // ***************************************************
    // mask gates only the voltage faults; command errors always alert
    logic fault_any;
    logic cml_any;

    assign fault_any = o_stat_byte_ov | o_stat_byte_oth;
    assign cml_any   = o_stat_cml_ivd | o_stat_cml_ivc;
    assign o_alert   = (fault_any & ~i_alert_mask) | cml_any;

    // ***************************************************
    // checks
    // ***************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!rst_n_r);

    ov_flags_a: assert property (
        ev_ov |=> o_stat_byte_ov && o_stat_word_vout && o_stat_vout_ov
                  && (o_alert || i_alert_mask))
        else $error("overvoltage flags or alert missing");
    uv_flags_a: assert property (
        ev_uv |=> o_stat_byte_oth && o_stat_word_vout && o_stat_vout_uv
                  && (o_alert || i_alert_mask))
        else $error("undervoltage flags or alert missing");
    slave_nack_a: assert property (
        slave_hit |=> o_cmd_done && o_cmd_nack && o_stat_cml_ivc && o_alert)
        else $error("loop slave access not refused");
    slave_keep_a: assert property (
        wr_req && slave_s |=> $stable(sel_r) && $stable(rbit_r))
        else $error("loop slave write changed a response byte");
    bad_retry_a: assert property (
        wr_bad |=> $stable(rbit_r) && $stable(sel_r) && o_stat_byte_cml
                   && o_stat_cml_ivd && o_alert && !o_cmd_nack)
        else $error("illegal retry write not rejected");
    good_write_a: assert property (
        wr_ok && hit[vuf_pkg::CH_OV] |=>
        rbit_r[vuf_pkg::CH_OV] == $past(i_cmd_wdata[vuf_pkg::RETRY_MSB]))
        else $error("accepted write not stored");
    mirror_a: assert property (
        o_cmd_done && !o_cmd_nack |->
        o_cmd_rdata[2:0] == {3{o_cmd_rdata[vuf_pkg::RETRY_MSB]}}
        && !o_cmd_rdata[vuf_pkg::ZERO_BIT])
        else $error("read image inconsistent");
    store_a: assert property (
        i_store_all |=> o_nvm_wr ##1 !o_nvm_wr || $past(i_store_all))
        else $error("store-all did not save");
    out_off_a: assert property (
        |ch_shut |=> !o_output_en)
        else $error("output on during shutdown");

    ov_ignore_cv: cover property (ev_ov && !sel_r[vuf_pkg::CH_OV]);
    uv_retry_cv:  cover property (ev_uv && sel_r[vuf_pkg::CH_UV] && rbit_r[vuf_pkg::CH_UV]);
    bad_wr_cv:    cover property (wr_bad);
endmodule
`default_nettype wire

// ===== tb/vuf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module vuf_host_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_cmd_done,
    input  wire logic       i_cmd_nack,
    input  wire logic [7:0] i_cmd_rdata,
    output logic            o_cmd_valid,
    output logic            o_cmd_write,
    output logic [7:0]      o_cmd_code,
    output logic [7:0]      o_cmd_wdata
);
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_write = 1'b0;
        o_cmd_code  = 8'h00;
        o_cmd_wdata = 8'h00;
    end
    // one request; the answer stands only in the cycle after the accepting edge
    task automatic xfer(input logic wr, input logic [7:0] cd, input logic [7:0] wd,
                        output logic dn, output logic nk, output logic [7:0] rd);
        @(posedge i_clk_sys);
        o_cmd_valid <= 1'b1;
        o_cmd_write <= wr;
        o_cmd_code  <= cd;
        o_cmd_wdata <= wd;
        @(posedge i_clk_sys);
        o_cmd_valid <= 1'b0;
        // released data must not keep showing the old byte
        o_cmd_wdata <= ~wd;
        o_cmd_code  <= ~cd;
        #1;
        dn = i_cmd_done;
        nk = i_cmd_nack;
        rd = i_cmd_rdata;
    endtask
endmodule
`default_nettype wire

// ===== tb/vuf_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module vuf_top_tb_top;
    localparam int RC = 20;
    logic i_clk_sys = 1'b0, i_rstn = 1'b0, ov = 1'b0, uv = 1'b0, ls = 1'b0;
    logic st = 1'b0, clr = 1'b0, on = 1'b1, msk = 1'b0;
    logic vld, wr, done, nack, nvw, oen, s_ov, s_oth, s_cml, s_wv, s_vov, s_vuv, ivd, invalid_command_fault, alr;
    logic [7:0] code, wd, rdat;
    logic [3:0] nvd;
    int errors = 0;
    int cmp_count = 0;
    logic dn, nk;
    logic [7:0] rb;
    always #50 i_clk_sys = ~i_clk_sys;
    vuf_top #(.RESTART_CYC(RC)) dut_u (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
        .i_ov_det(ov), .i_uv_det(uv), .i_loop_slave(ls), .i_cmd_valid(vld), .i_cmd_write(wr),
        .i_cmd_code(code), .i_cmd_wdata(wd), .i_store_all(st), .i_clear_faults(clr),
        .i_output_on(on), .i_alert_mask(msk), .o_cmd_done(done), .o_cmd_nack(nack),
        .o_cmd_rdata(rdat), .o_nvm_wr(nvw), .o_nvm_data(nvd), .o_output_en(oen),
        .o_stat_byte_ov(s_ov), .o_stat_byte_oth(s_oth), .o_stat_byte_cml(s_cml),
        .o_stat_word_vout(s_wv), .o_stat_vout_ov(s_vov), .o_stat_vout_uv(s_vuv),
        .o_stat_cml_ivd(ivd), .o_stat_cml_ivc(invalid_command_fault), .o_alert(alr));
    vuf_host_model host_u (.i_clk_sys(i_clk_sys), .i_cmd_done(done), .i_cmd_nack(nack),
        .i_cmd_rdata(rdat), .o_cmd_valid(vld), .o_cmd_write(wr), .o_cmd_code(code),
        .o_cmd_wdata(wd));
    // ***************************************************
    // helpers
    // ***************************************************
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic wreg(input logic [7:0] cd, input logic [7:0] d);
        host_u.xfer(1'b1, cd, d, dn, nk, rb);
        chk("wr done", 8'h01, {7'h0, dn & ~nk});
    endtask
    task automatic rreg(input logic [7:0] cd, input logic [7:0] exp);
        host_u.xfer(1'b0, cd, 8'h00, dn, nk, rb);
        chk("rd done", 8'h01, {7'h0, dn & ~nk});
        chk("rd byte", exp, rb);
    endtask
    task automatic clear();
        @(posedge i_clk_sys);
        clr <= 1'b1;
        @(posedge i_clk_sys);
        clr <= 1'b0;
        cyc(4);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ***************************************************
    // scenarios
    // ***************************************************
    task automatic t_defaults();
        rreg(8'h41, 8'hbf);
        rreg(8'h45, 8'hbf);
        chk("out en", 8'h01, {7'h0, oen});
        @(posedge i_clk_sys);
        on <= 1'b0;
        cyc(2);
        chk("out off", 8'h00, {7'h0, oen});
        @(posedge i_clk_sys);
        on <= 1'b1;
        cyc(2);
    endtask
    task automatic t_loop();
        @(posedge i_clk_sys);
        ls <= 1'b1;
        cyc(4);
        host_u.xfer(1'b1, 8'h41, 8'h00, dn, nk, rb);
        chk("ls wr nack", 8'h03, {6'h0, dn, nk});
        host_u.xfer(1'b0, 8'h45, 8'h00, dn, nk, rb);
        chk("ls rd nack", 8'h03, {6'h0, dn, nk});
        cyc(1);
        chk("ls flags", 8'h07, {5'h0, invalid_command_fault, s_cml, alr});
        @(posedge i_clk_sys);
        ls <= 1'b0;
        cyc(4);
        clear();
        rreg(8'h41, 8'hbf);
    endtask
    task automatic t_legal();
        wreg(8'h41, 8'h47);
        rreg(8'h41, 8'h00);
        wreg(8'h45, 8'h7f);
        rreg(8'h45, 8'h3f);
        wreg(8'h41, 8'hb8);
        rreg(8'h41, 8'hbf);
    endtask
    task automatic t_bad();
        for (int r = 1; r < 7; r++) begin
            wreg(8'h41, {2'b00, r[2:0], 3'b000});
            cyc(1);
            chk("bad flags", 8'h07, {5'h0, ivd, s_cml, alr});
            rreg(8'h41, 8'hbf);
            clear();
        end
    endtask
    task automatic t_store();
        wreg(8'h41, 8'h00);
        wreg(8'h45, 8'hbf);
        @(posedge i_clk_sys);
        st <= 1'b1;
        @(posedge i_clk_sys);
        st <= 1'b0;
        #1;
        chk("nvm", 8'h1c, {3'h0, nvw, nvd});
    endtask
    task automatic t_ov_hold();
        wreg(8'h41, 8'h80);
        @(posedge i_clk_sys);
        ov <= 1'b1;
        cyc(6);
        chk("ov flags", 8'h1e, {3'h0, s_ov, s_wv, s_vov, alr, oen});
        @(posedge i_clk_sys);
        ov <= 1'b0;
        cyc(RC + 20);
        chk("ov held", 8'h00, {7'h0, oen});
        clear();
        chk("ov clr", 8'h01, {3'h0, s_ov, s_wv, s_vov, alr, oen});
    endtask
    task automatic t_uv_retry();
        int n;
        wreg(8'h45, 8'hbf);
        @(posedge i_clk_sys);
        uv <= 1'b1;
        cyc(3);
        @(posedge i_clk_sys);
        uv <= 1'b0;
        cyc(3);
        chk("uv flags", 8'h1e, {3'h0, s_oth, s_wv, s_vuv, alr, oen});
        cyc(RC / 2);
        chk("uv wait", 8'h00, {7'h0, oen});
        n = 0;
        while (oen !== 1'b1 && n < 2 * RC + 10) begin
            cyc(1);
            n++;
        end
        chk("uv restart", 8'h01, {7'h0, oen});
        clear();
    endtask
    task automatic t_ignore();
        wreg(8'h41, 8'h3f);
        @(posedge i_clk_sys);
        msk <= 1'b1;
        ov <= 1'b1;
        cyc(6);
        chk("ign masked", 8'h05, {5'h0, s_vov, alr, oen});
        @(posedge i_clk_sys);
        msk <= 1'b0;
        cyc(1);
        chk("ign alert", 8'h07, {5'h0, s_vov, alr, oen});
        @(posedge i_clk_sys);
        ov <= 1'b0;
        clear();
    endtask
    // ***************************************************
    // main sequence and watchdog
    // ***************************************************
    initial begin
        repeat (8) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        cyc(5);
        t_defaults();
        t_loop();
        t_legal();
        t_bad();
        t_store();
        t_ov_hold();
        t_uv_retry();
        t_ignore();
        give_verdict();
    end
    // run needs well under a thousand cycles; this leaves wide room
    initial begin
        #(100 * 5000);
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
